// [pkg/sdp_ram_pkg.sv]
// constants, types and register map of the small simple dual-port ram
// assumes a single 200 MHz system clock and an apb register master

package sdp_ram_pkg;

    // ------------------------------------------------------------
    // storage geometry
    // ------------------------------------------------------------
    localparam int MEM_BITS = 576;
    localparam int DATA_W = 18;
    localparam int ADDR_W = 9;
    localparam int PHYS_W = 10;
    localparam int CNT_W = 10;

    // ------------------------------------------------------------
    // shape codes: 512x1 256x2 128x4 64x8 64x9 32x16 32x18
    // ------------------------------------------------------------
    localparam logic [2:0] SHAPE_X1 = 3'h0;
    localparam logic [2:0] SHAPE_X2 = 3'h1;
    localparam logic [2:0] SHAPE_X4 = 3'h2;
    localparam logic [2:0] SHAPE_X8 = 3'h3;
    localparam logic [2:0] SHAPE_X9 = 3'h4;
    localparam logic [2:0] SHAPE_X16 = 3'h5;
    localparam logic [2:0] SHAPE_X18 = 3'h6;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [11:0] CTRL_OFF = 12'h000;
    localparam logic [11:0] STATUS_OFF = 12'h004;
    localparam logic [11:0] INIT_ADDR_OFF = 12'h008;
    localparam logic [11:0] INIT_DATA_OFF = 12'h00c;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0c36;

    // ------------------------------------------------------------
    // fill value shown on a collision in unknown-output mode
    // ------------------------------------------------------------
    localparam logic [17:0] RDW_FILL = 18'h2aaaa;

    typedef enum logic [2:0] {
        MODE_SDP,
        MODE_SP,
        MODE_FIFO,
        MODE_ROM,
        MODE_SHIFT
    } ram_mode_t;

    typedef enum logic [1:0] {
        CLK_CUSTOM,
        CLK_READ_WRITE,
        CLK_INPUT_OUTPUT
    } clk_mode_t;

    typedef struct packed {
        logic [15:0] spare;
        logic out_sel;
        logic rd_sel;
        logic wr_sel;
        logic [1:0] clk_mode;
        logic rdw_unknown;
        logic out_bypass;
        logic [2:0] rd_shape;
        logic [2:0] wr_shape;
        logic [2:0] mode;
    } ctrl_t;

endpackage

// [hw/sdp_ram.sv]
// small 576-bit simple dual-port ram with apb configuration
// assumes user logic on i_mclk; its two block clocks arrive as tick enables
//
// Overview of operation
// - one write port and one separate read port, never two read/write ports.
// - 576 bits with parity, shapes 512x1 through 32x18.
// - acts as simple dual-port ram, single-port ram, fifo, rom or shift register.
// - write and read ports may use different shapes over the same storage in simple dual-port and rom modes.
// - write enable, data and address registers share one selectable clock.
// - read address and read enable share one selectable clock; the output register picks either clock.
// - read/write and input/output clock arrangements are both supported.
// - only the output register may be bypassed; input registers always exist.
// - ram or rom contents can be preloaded before normal operation.
//
// Design decisions made here: the APB register port and the register addresses.

`timescale 1ns/1ps

module sdp_ram
    import sdp_ram_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_clk0_tick,
    input wire logic i_clk1_tick,
    input wire logic i_clk0_ce,
    input wire logic i_clk1_ce,
    input wire logic i_wren,
    input wire logic [ADDR_W-1:0] i_waddr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic [1:0] i_byteen,
    input wire logic i_rden,
    input wire logic [ADDR_W-1:0] i_raddr,
    input wire logic i_outclr,
    output logic [DATA_W-1:0] o_rdata,
    output logic o_fifo_empty,
    output logic o_fifo_full,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr
);

    // ------------------------------------------------------------
    // shape helpers
    // ------------------------------------------------------------
    function automatic logic [4:0] width_of(input logic [2:0] s);
        case (s)
            SHAPE_X1: width_of = 5'h01;
            SHAPE_X2: width_of = 5'h02;
            SHAPE_X4: width_of = 5'h04;
            SHAPE_X8: width_of = 5'h08;
            SHAPE_X9: width_of = 5'h09;
            SHAPE_X16: width_of = 5'h10;
            default: width_of = 5'h12;
        endcase
    endfunction

    function automatic logic [ADDR_W-1:0] mask_of(input logic [2:0] s);
        case (s)
            SHAPE_X1: mask_of = 9'h1ff;
            SHAPE_X2: mask_of = 9'h0ff;
            SHAPE_X4: mask_of = 9'h07f;
            SHAPE_X8, SHAPE_X9: mask_of = 9'h03f;
            default: mask_of = 9'h01f;
        endcase
    endfunction

    // parity shapes use all 9 bits of a byte; plain shapes skip bit 8 of each
    function automatic logic [PHYS_W-1:0] phys(input logic [2:0] s,
                                               input logic [ADDR_W-1:0] a,
                                               input logic [4:0] k);
        logic [13:0] lin;
        logic [13:0] tmp;
        lin = 14'(a) * 14'(width_of(s)) + 14'(k);
        tmp = 14'(lin[13:3]) * 14'h0009 + 14'(lin[2:0]);
        if (s == SHAPE_X9 || s == SHAPE_X18) begin
            phys = lin[PHYS_W-1:0];
        end else begin
            phys = tmp[PHYS_W-1:0];
        end
    endfunction

    function automatic logic lane_on(input logic [2:0] s, input logic [1:0] be,
                                     input logic [4:0] k);
        logic on;
        on = 1'b0;
        if (k < width_of(s)) begin
            case (s)
                SHAPE_X16: on = be[k >= 5'h08];
                SHAPE_X18: on = be[k >= 5'h09];
                default: on = be[0];
            endcase
        end
        lane_on = on;
    endfunction

    // ------------------------------------------------------------
    // configuration and apb slave
    // ------------------------------------------------------------
    ctrl_t ctrl;
    ctrl_t next_ctrl;
    logic [4:0] init_addr;
    logic [4:0] next_init_addr;
    logic [31:0] prdata;
    logic [31:0] next_prdata;
    logic pready;
    logic next_pready;
    logic pslverr;
    logic next_pslverr;
    logic init_we;
    logic [DATA_W-1:0] init_word;
    logic [MEM_BITS-1:0] mem;
    logic [CNT_W-1:0] fifo_cnt;

    logic wr_sel;
    logic rd_sel;
    logic out_sel;
    logic wtick;
    logic rtick;
    logic otick;
    logic [CNT_W-1:0] wr_depth;

    always_comb begin
        case (clk_mode_t'(ctrl.clk_mode))
            CLK_READ_WRITE: begin
                wr_sel = 1'b0;
                rd_sel = 1'b1;
                out_sel = 1'b1;
            end
            CLK_INPUT_OUTPUT: begin
                wr_sel = 1'b0;
                rd_sel = 1'b0;
                out_sel = 1'b1;
            end
            default: begin
                wr_sel = ctrl.wr_sel;
                rd_sel = ctrl.rd_sel;
                out_sel = ctrl.out_sel;
            end
        endcase
        wtick = wr_sel ? (i_clk1_tick & i_clk1_ce) : (i_clk0_tick & i_clk0_ce);
        rtick = rd_sel ? (i_clk1_tick & i_clk1_ce) : (i_clk0_tick & i_clk0_ce);
        otick = out_sel ? (i_clk1_tick & i_clk1_ce) : (i_clk0_tick & i_clk0_ce);
        wr_depth = {1'b0, mask_of(ctrl.wr_shape)} + 10'h001;
    end

    always_comb begin
        logic hit;
        hit = 1'b1;
        next_ctrl = ctrl;
        next_init_addr = init_addr;
        next_prdata = prdata;
        next_pslverr = 1'b0;
        next_pready = i_psel & i_penable & ~pready;
        init_we = 1'b0;
        init_word = i_pwdata[DATA_W-1:0];
        for (int k = 0; k < DATA_W; k++) begin
            next_prdata[k] = mem[10'(init_addr) * 10'h012 + 10'(k)];
        end
        case (i_paddr)
            CTRL_OFF: next_prdata = ctrl;
            STATUS_OFF: next_prdata = {6'h00, fifo_cnt, 14'h0000, o_fifo_full, o_fifo_empty};
            INIT_ADDR_OFF: next_prdata = {27'h0000000, init_addr};
            INIT_DATA_OFF: next_prdata[31:DATA_W] = 14'h0000;
            default: begin
                hit = 1'b0;
                next_prdata = 32'h0000_0000;
            end
        endcase
        if (i_psel & i_penable & ~pready) begin
            next_pslverr = ~hit;
        end
        if (i_psel & i_penable & pready & i_pwrite) begin
            case (i_paddr)
                CTRL_OFF: next_ctrl = ctrl_t'({16'h0000, i_pwdata[15:0]});
                INIT_ADDR_OFF: next_init_addr = i_pwdata[4:0];
                INIT_DATA_OFF: begin
                    init_we = 1'b1;
                    next_init_addr = init_addr + 5'h01;
                end
                default: next_ctrl = ctrl;
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ctrl <= ctrl_t'(CTRL_RESET);
            init_addr <= 5'h00;
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            ctrl <= next_ctrl;
            init_addr <= next_init_addr;
            prdata <= next_prdata;
            pready <= next_pready;
            pslverr <= next_pslverr;
        end
    end

    assign o_prdata = prdata;
    assign o_pready = pready;
    assign o_pslverr = pslverr & pready;

    // ------------------------------------------------------------
    // input registers, fifo pointers and read capture
    // ------------------------------------------------------------
    // input registers are always present, so every access costs one tick
    logic wen_q, next_wen_q;
    logic [ADDR_W-1:0] waddr_q, next_waddr_q;
    logic [DATA_W-1:0] wdata_q, next_wdata_q;
    logic [1:0] be_q, next_be_q;
    logic ren_q, next_ren_q;
    logic [ADDR_W-1:0] raddr_q, next_raddr_q;
    logic [ADDR_W-1:0] wptr, next_wptr;
    logic [ADDR_W-1:0] rptr, next_rptr;
    logic [CNT_W-1:0] next_fifo_cnt;
    logic [DATA_W-1:0] rd_word, next_rd_word;
    logic [DATA_W-1:0] out_q, next_out_q;
    logic [DATA_W-1:0] gather;
    logic [2:0] rshape;

    always_comb begin
        logic push;
        logic pop;
        ram_mode_t mode;
        mode = ram_mode_t'(ctrl.mode);
        push = 1'b0;
        pop = 1'b0;
        next_wen_q = 1'b0;
        next_ren_q = 1'b0;
        next_waddr_q = waddr_q;
        next_wdata_q = wdata_q;
        next_be_q = be_q;
        next_raddr_q = raddr_q;
        next_wptr = wptr;
        next_rptr = rptr;
        next_fifo_cnt = fifo_cnt;
        rshape = ctrl.rd_shape;
        if (mode == MODE_FIFO || mode == MODE_SHIFT || mode == MODE_SP) begin
            rshape = ctrl.wr_shape;
        end
        if (wtick) begin
            next_wen_q = i_wren & (mode != MODE_ROM);
            next_waddr_q = i_waddr & mask_of(ctrl.wr_shape);
            next_wdata_q = i_wdata;
            next_be_q = i_byteen;
        end
        if (rtick) begin
            next_ren_q = i_rden;
            next_raddr_q = i_raddr & mask_of(ctrl.rd_shape);
        end
        case (mode)
            MODE_SP: begin
                next_ren_q = wtick & i_rden;
                next_raddr_q = wtick ? next_waddr_q : raddr_q;
            end
            MODE_FIFO: begin
                push = wtick & i_wren & ~o_fifo_full;
                pop = rtick & i_rden & ~o_fifo_empty;
                next_wen_q = push;
                next_ren_q = pop;
                next_waddr_q = push ? wptr : waddr_q;
                next_raddr_q = pop ? rptr : raddr_q;
                next_wptr = push ? ((wptr == mask_of(ctrl.wr_shape)) ? 9'h000 : wptr + 9'h001) : wptr;
                next_rptr = pop ? ((rptr == mask_of(ctrl.wr_shape)) ? 9'h000 : rptr + 9'h001) : rptr;
                next_fifo_cnt = fifo_cnt + 10'(push) - 10'(pop);
            end
            MODE_SHIFT: begin
                // the tap is read before it is overwritten: delay of one depth
                push = wtick & i_wren;
                next_wen_q = push;
                next_ren_q = push;
                next_waddr_q = push ? wptr : waddr_q;
                next_raddr_q = push ? wptr : raddr_q;
                next_wptr = push ? ((wptr == mask_of(ctrl.wr_shape)) ? 9'h000 : wptr + 9'h001) : wptr;
            end
            default: next_fifo_cnt = fifo_cnt;
        endcase
        for (int k = 0; k < DATA_W; k++) begin
            gather[k] = (5'(k) < width_of(rshape)) ? mem[phys(rshape, raddr_q, 5'(k))] : 1'b0;
        end
        next_rd_word = rd_word;
        if (ren_q) begin
            next_rd_word = gather;
            if (wen_q && ctrl.rdw_unknown && mode != MODE_SHIFT &&
                waddr_q == raddr_q && ctrl.wr_shape == rshape) begin
                next_rd_word = RDW_FILL;
            end
        end
        next_out_q = out_q;
        if (otick) begin
            next_out_q = rd_word;
        end
        if (i_outclr) begin
            next_out_q = 18'h00000;
            next_rd_word = 18'h00000;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            wen_q <= 1'b0;
            waddr_q <= 9'h000;
            wdata_q <= 18'h00000;
            be_q <= 2'h0;
            ren_q <= 1'b0;
            raddr_q <= 9'h000;
            wptr <= 9'h000;
            rptr <= 9'h000;
            fifo_cnt <= 10'h000;
            rd_word <= 18'h00000;
            out_q <= 18'h00000;
        end else begin
            wen_q <= next_wen_q;
            waddr_q <= next_waddr_q;
            wdata_q <= next_wdata_q;
            be_q <= next_be_q;
            ren_q <= next_ren_q;
            raddr_q <= next_raddr_q;
            wptr <= next_wptr;
            rptr <= next_rptr;
            fifo_cnt <= next_fifo_cnt;
            rd_word <= next_rd_word;
            out_q <= next_out_q;
        end
    end

    assign o_rdata = ctrl.out_bypass ? rd_word : out_q;
    assign o_fifo_empty = (fifo_cnt == 10'h000);
    assign o_fifo_full = (fifo_cnt == wr_depth);

    // ------------------------------------------------------------
    // storage array
    // ------------------------------------------------------------
    // contents survive reset so a preload is not lost
    logic [MEM_BITS-1:0] next_mem;

    always_comb begin
        next_mem = mem;
        if (init_we) begin
            for (int k = 0; k < DATA_W; k++) begin
                next_mem[10'(init_addr) * 10'h012 + 10'(k)] = init_word[k];
            end
        end
        if (wen_q) begin
            for (int k = 0; k < DATA_W; k++) begin
                if (lane_on(ctrl.wr_shape, be_q, 5'(k))) begin
                    next_mem[phys(ctrl.wr_shape, waddr_q, 5'(k))] = wdata_q[k];
                end
            end
        end
    end

    always_ff @(posedge i_mclk) begin
        mem <= next_mem;
    end

endmodule

// [verification/sdp_ram_properties.sv]
// concurrent checks on the ports of the small dual-port ram
// assumes one clock, i_mclk, and sync reset i_srst
`timescale 1ns/1ps

module sdp_ram_properties
    import sdp_ram_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_clk0_tick,
    input wire logic i_clk1_tick,
    input wire logic i_outclr,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [DATA_W-1:0] o_rdata,
    input wire logic o_fifo_empty,
    input wire logic o_fifo_full,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr
);
    default clocking cb @(posedge i_mclk); endclocking
    logic mapped;
    logic tick_any;
    logic apb_wr;
    assign mapped = i_paddr inside {CTRL_OFF, STATUS_OFF, INIT_ADDR_OFF, INIT_DATA_OFF};
    assign tick_any = i_clk0_tick | i_clk1_tick;
    // a register write may flip the bypass and so move the read data
    assign apb_wr = i_psel && i_penable && o_pready && i_pwrite;

    // ------------------------------------------------------------
    // sequences and checks
    // ------------------------------------------------------------
    sequence apb_start;
        i_psel && !i_penable ##1 i_psel && i_penable;
    endsequence

    a_reset_out_zero:
    assert property (i_srst |=> o_rdata == '0 && o_fifo_empty && !o_fifo_full && !o_pready)
        else $error("outputs not cleared by reset");
    a_clear_out_zero:
    assert property (disable iff (i_srst) i_outclr |=> o_rdata == '0)
        else $error("output clear ignored");
    a_apb_one_wait:
    assert property (disable iff (i_srst) apb_start |-> !o_pready ##1 o_pready)
        else $error("ready not after one wait state");
    a_ready_one_cycle:
    assert property (disable iff (i_srst) o_pready |=> !o_pready)
        else $error("ready longer than one cycle");
    a_slverr_with_ready:
    assert property (disable iff (i_srst) o_pslverr |-> o_pready)
        else $error("error without ready");
    a_unmapped_read_err:
    assert property (disable iff (i_srst)
        i_psel && i_penable && o_pready && !mapped && !i_pwrite |-> o_pslverr && o_prdata == '0)
        else $error("unmapped read not refused");
    a_flags_exclusive:
    assert property (disable iff (i_srst) !(o_fifo_full && o_fifo_empty))
        else $error("fifo full and empty together");
    a_rdata_on_tick:
    assert property (disable iff (i_srst) $changed(o_rdata) |-> $past(tick_any)
        || $past(tick_any, 2) || $past(tick_any, 3) || $past(i_outclr) || $past(i_srst)
        || $past(apb_wr))
        else $error("read data moved without a tick");
endmodule

bind sdp_ram sdp_ram_properties sdp_ram_properties_inst (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_clk0_tick(i_clk0_tick), .i_clk1_tick(i_clk1_tick),
    .i_outclr(i_outclr), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
    .i_paddr(i_paddr), .o_rdata(o_rdata), .o_fifo_empty(o_fifo_empty),
    .o_fifo_full(o_fifo_full), .o_prdata(o_prdata), .o_pready(o_pready),
    .o_pslverr(o_pslverr)
);

// [verification/user_logic_model.sv]
// tick source standing in for the user logic clocks
// assumes one system clock; i_slow halves the read-side tick rate
`timescale 1ns/1ps

module user_logic_model (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_slow,
    output logic o_clk0_tick,
    output logic o_clk1_tick
);
    logic phase;
    logic next_phase;

    always_comb begin
        next_phase = i_slow ? !phase : 1'b1;
    end

    always_ff @(posedge i_mclk) begin
        phase <= i_srst ? 1'b0 : next_phase;
    end

    // both block clocks come from the user side
    assign o_clk0_tick = !i_srst;
    assign o_clk1_tick = phase;
endmodule

// [verification/small_simple_dual_port_ram_test.sv]
// self-checking bench for the small dual-port ram
// assumes clock mode read/write: writes on tick 0, reads on tick 1
`timescale 1ns/1ps

module small_simple_dual_port_ram_test
    import sdp_ram_pkg::*;
;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0;
    logic wren = 1'b0;
    logic [8:0] waddr = 9'h0;
    logic [17:0] wdata = 18'h0;
    logic [1:0] byteen = 2'h3;
    logic rden = 1'b0;
    logic [8:0] raddr = 9'h0;
    logic outclr = 1'b0;
    logic ce0 = 1'b1;
    logic ce1 = 1'b1;
    logic slow = 1'b0;
    logic t0;
    logic t1;
    logic [17:0] rdata;
    logic empty;
    logic full;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [31:0] rd;
    logic err;
    int num_errors = 0;
    int checked = 0;

    user_logic_model user_logic_model_inst (.i_mclk(mclk), .i_srst(srst), .i_slow(slow),
        .o_clk0_tick(t0), .o_clk1_tick(t1));
    sdp_ram sdp_ram_inst (.i_mclk(mclk), .i_srst(srst), .i_clk0_tick(t0), .i_clk1_tick(t1),
        .i_clk0_ce(ce0), .i_clk1_ce(ce1), .i_wren(wren), .i_waddr(waddr), .i_wdata(wdata),
        .i_byteen(byteen), .i_rden(rden), .i_raddr(raddr), .i_outclr(outclr),
        .o_rdata(rdata), .o_fifo_empty(empty), .o_fifo_full(full), .i_psel(psel),
        .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
        .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr));

    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    function automatic logic [31:0] ctl(logic [2:0] m, logic [2:0] w, logic [2:0] r,
        logic b, logic u);
        ctrl_t c;
        c = '0;
        c.mode = m;
        c.wr_shape = w;
        c.rd_shape = r;
        c.out_bypass = b;
        c.rdw_unknown = u;
        c.clk_mode = 2'h1;
        return c;
    endfunction

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        checked++;
        if (s !== e) begin
            num_errors++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rchk(input logic [17:0] e);
        chk("rdata", {14'h0, e}, {14'h0, rdata});
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        do @(posedge mclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic uwr(input logic [8:0] a, input logic [17:0] d, input logic [1:0] be);
        @(posedge mclk);
        wren <= 1'b1;
        waddr <= a;
        wdata <= d;
        byteen <= be;
        do @(posedge mclk); while (t0 !== 1'b1);
        wren <= 1'b0;
    endtask

    // bypassed read data settles one edge after the capturing tick
    task automatic urd(input logic [8:0] a);
        @(posedge mclk);
        rden <= 1'b1;
        raddr <= a;
        do @(posedge mclk); while (t1 !== 1'b1);
        rden <= 1'b0;
        @(posedge mclk);
        #1;
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // clock, watchdog, tests
    // ------------------------------------------------------------
    initial begin
        forever #2.5 mclk = ~mclk;
    end

    initial begin
        repeat (20000) @(posedge mclk);
        num_errors++;
        end_sim();
    end

    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        apb(1'b0, CTRL_OFF, 32'h0);
        chk("ctrl", CTRL_RESET, rd);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("status", 32'h1, rd);
        rchk(18'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        for (int m = 0; m < 5; m++) begin
            apb(1'b1, CTRL_OFF, ctl(3'(m), SHAPE_X18, SHAPE_X9, 1'b0, 1'b1));
            apb(1'b0, CTRL_OFF, 32'h0);
            chk("mode", ctl(3'(m), SHAPE_X18, SHAPE_X9, 1'b0, 1'b1), rd);
        end
        apb(1'b1, CTRL_OFF, ctl(MODE_SDP, SHAPE_X18, SHAPE_X18, 1'b1, 1'b0));
        uwr(9'h3, 18'h12345, 2'h3);
        urd(9'h3);
        rchk(18'h12345);
        apb(1'b1, CTRL_OFF, ctl(MODE_SDP, SHAPE_X18, SHAPE_X9, 1'b1, 1'b0));
        urd(9'h6);
        rchk(18'h145);
        urd(9'h7);
        rchk(18'h091);
        apb(1'b1, CTRL_OFF, ctl(MODE_SDP, SHAPE_X18, SHAPE_X8, 1'b1, 1'b0));
        urd(9'h6);
        rchk(18'h045);
        apb(1'b1, CTRL_OFF, ctl(MODE_SDP, SHAPE_X18, SHAPE_X18, 1'b1, 1'b0));
        uwr(9'h3, 18'h0, 2'h1);
        urd(9'h3);
        rchk(18'h12200);
        @(posedge mclk);
        ce0 <= 1'b0;
        uwr(9'h3, 18'h3ffff, 2'h3);
        ce0 <= 1'b1;
        urd(9'h3);
        rchk(18'h12200);
        for (int u = 1; u >= 0; u--) begin
            apb(1'b1, CTRL_OFF, ctl(MODE_SDP, SHAPE_X18, SHAPE_X18, 1'b1, u[0]));
            @(posedge mclk);
            wren <= 1'b1;
            rden <= 1'b1;
            waddr <= 9'h4;
            raddr <= 9'h4;
            wdata <= u ? 18'h00111 : 18'h00222;
            byteen <= 2'h3;
            @(posedge mclk);
            wren <= 1'b0;
            rden <= 1'b0;
            repeat (2) @(posedge mclk);
            #1;
            rchk(u ? RDW_FILL : 18'h00111);
        end
        // registered output with a slow read clock lags the bypass path
        apb(1'b1, CTRL_OFF, ctl(MODE_SDP, SHAPE_X18, SHAPE_X18, 1'b0, 1'b0));
        slow <= 1'b1;
        @(posedge mclk);
        outclr <= 1'b1;
        @(posedge mclk);
        outclr <= 1'b0;
        #1;
        rchk(18'h0);
        // rd_word has loaded but the next output tick has not come yet
        urd(9'h3);
        rchk(18'h0);
        repeat (3) @(posedge mclk);
        #1;
        rchk(18'h12200);
        @(posedge mclk);
        slow <= 1'b0;
        apb(1'b1, INIT_ADDR_OFF, 32'h5);
        apb(1'b1, INIT_DATA_OFF, 32'h0abcd);
        apb(1'b1, INIT_DATA_OFF, 32'h1beef);
        apb(1'b0, INIT_ADDR_OFF, 32'h0);
        chk("init_addr", 32'h7, rd);
        apb(1'b1, INIT_ADDR_OFF, 32'h6);
        apb(1'b0, INIT_DATA_OFF, 32'h0);
        chk("init_data", 32'h1beef, rd);
        apb(1'b1, CTRL_OFF, ctl(MODE_ROM, SHAPE_X18, SHAPE_X18, 1'b1, 1'b0));
        uwr(9'h5, 18'h0, 2'h3);
        urd(9'h5);
        rchk(18'h0abcd);
        // single port: the read follows the write address, not the read address
        apb(1'b1, CTRL_OFF, ctl(MODE_SP, SHAPE_X18, SHAPE_X18, 1'b1, 1'b0));
        @(posedge mclk);
        rden <= 1'b1;
        waddr <= 9'h6;
        @(posedge mclk);
        rden <= 1'b0;
        @(posedge mclk);
        #1;
        rchk(18'h1beef);
        apb(1'b1, CTRL_OFF, ctl(MODE_FIFO, SHAPE_X18, SHAPE_X18, 1'b1, 1'b0));
        for (int i = 0; i < 33; i++) uwr(9'h0, 18'(i + 7), 2'h3);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("status", 32'h0020_0002, rd);
        chk("full", 32'h1, {31'h0, full});
        urd(9'h0);
        rchk(18'h7);
        apb(1'b0, STATUS_OFF, 32'h0);
        chk("status", 32'h001f_0000, rd);
        // shift tap: the 33rd shift returns the word shifted in 32 steps earlier
        apb(1'b1, CTRL_OFF, ctl(MODE_SHIFT, SHAPE_X18, SHAPE_X18, 1'b1, 1'b0));
        for (int i = 0; i < 33; i++) uwr(9'h0, 18'(i + 256), 2'h3);
        @(posedge mclk);
        #1;
        rchk(18'h00100);
        end_sim();
    end
endmodule
